// ---- verilog/swr_defines.svh ----
`ifndef SWR_DEFINES_SVH
`define SWR_DEFINES_SVH

// Clock and timing tick
`define SWR_CLK_NS 10
`define SWR_TICK_CYC 25
`define SWR_TICK_NS (`SWR_CLK_NS * `SWR_TICK_CYC)
`define SWR_TK_UP(ns) (((ns) + `SWR_TICK_NS - 1) / `SWR_TICK_NS)
`define SWR_TK_DN(ns) ((ns) / `SWR_TICK_NS)
`define SWR_CYC_DN(ns) ((ns) / `SWR_CLK_NS)
`define SWR_CYC_UP(ns) (((ns) + `SWR_CLK_NS - 1) / `SWR_CLK_NS)

// Reset and presence, regular speed
`define SWR_RST_REG_NS 500000
`define SWR_RST_REG_MIN_NS 480000
`define SWR_RST_REG_MAX_NS 960000
`define SWR_PD_REG_NS 70000
`define SWR_REC_REG_NS 480000
// Reset and presence, fast speed
`define SWR_RST_OD_NS 70000
`define SWR_RST_OD_MIN_NS 48000
`define SWR_RST_OD_KEEP_NS 80000
`define SWR_PD_OD_NS 8000
`define SWR_REC_OD_NS 48000

// Bit slots
`define SWR_SLOT_REG_NS 70000
`define SWR_W0_REG_NS 65000
`define SWR_SHORT_REG_NS 6000
`define SWR_RD_REG_NS 13000
`define SWR_SLOT_OD_NS 10000
`define SWR_W0_OD_NS 7500
`define SWR_SHORT_OD_NS 1000
`define SWR_RD_OD_NS 2000

// Line low limits and bit rate
`define SWR_IDLE_LOW_REG_NS 120000
`define SWR_IDLE_LOW_OD_NS 16000
`define SWR_BIT_REG_MIN_NS 61350
`define SWR_BIT_OD_MIN_NS 7043

// Sizes and command codes
`define SWR_ID_BITS 64
`define SWR_BYTE_BITS 8
`define SWR_CMD_READ_ID 8'h33
`define SWR_CMD_MATCH 8'h55
`define SWR_CMD_SKIP 8'hCC
`define SWR_CMD_SEARCH 8'hF0
`define SWR_CMD_OD_SKIP 8'h3C
`define SWR_CMD_OD_MATCH 8'h69

`endif

// ---- verilog/swr_pkg.sv ----
package swr_pkg;
  typedef enum logic [1:0] {SWR_K_RESET, SWR_K_WRITE, SWR_K_READ} swr_kind_t;
  typedef enum logic [3:0] {SWR_OP_RESET, SWR_OP_READ_ID, SWR_OP_MATCH, SWR_OP_SKIP, SWR_OP_SEARCH,
    SWR_OP_OD_SKIP, SWR_OP_OD_MATCH, SWR_OP_WRITE_BYTE, SWR_OP_READ_BYTE} swr_op_t;
  typedef enum logic [1:0] {SWR_PH_NONE, SWR_PH_ROM, SWR_PH_MEM, SWR_PH_DATA} swr_phase_t;
  typedef enum logic [3:0] {SWR_ST_IDLE, SWR_ST_RST, SWR_ST_CMD, SWR_ST_ID_TX, SWR_ST_ID_RX, SWR_ST_SR_A,
    SWR_ST_SR_B, SWR_ST_SR_W, SWR_ST_BYTE_TX, SWR_ST_BYTE_RX} swr_state_t;
  typedef struct packed {
    swr_op_t op;
    logic long_rst;
    logic [7:0] data;
    logic [63:0] id;
  } swr_req_t;
  typedef struct packed {
    logic err;
    logic present;
    logic [7:0] data;
    logic [63:0] id;
  } swr_rsp_t;
  typedef struct packed {
    logic [11:0] low;
    logic [11:0] samp;
    logic [11:0] total;
  } swr_tim_t;
endpackage

// ---- verilog/swr_slot.sv ----
`timescale 1ns/1ps
`include "swr_defines.svh"
module swr_slot (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire swr_pkg::swr_kind_t i_kind,
  input wire logic i_bit,
  input wire logic i_fast,
  input wire logic i_dq,
  output logic o_done,
  output logic o_bit,
  output logic o_dq,
  output logic o_dq_oe_n
);
  logic [4:0] div, next_div;
  logic [11:0] t, next_t;
  logic busy, next_busy, done, next_done, smp, next_smp, oe_n, next_oe_n, fast_q, next_fast_q;
  swr_pkg::swr_kind_t kind, next_kind;
  swr_pkg::swr_tim_t tim, next_tim;
  logic [16:0] low_cyc, slot_cyc;

  function automatic swr_pkg::swr_tim_t slot_tim(input swr_pkg::swr_kind_t k, input logic b, input logic f);
    swr_pkg::swr_tim_t r;
    r = '0;
    case (k)
      swr_pkg::SWR_K_RESET: begin
        r.low = f ? 12'(`SWR_TK_UP(`SWR_RST_OD_NS)) : 12'(`SWR_TK_UP(`SWR_RST_REG_NS));
        r.samp = 12'(r.low + (f ? 12'(`SWR_TK_DN(`SWR_PD_OD_NS)) : 12'(`SWR_TK_DN(`SWR_PD_REG_NS))));
        r.total = 12'(r.low + (f ? 12'(`SWR_TK_UP(`SWR_REC_OD_NS)) : 12'(`SWR_TK_UP(`SWR_REC_REG_NS))));
      end
      swr_pkg::SWR_K_WRITE: begin
        if (b) begin
          r.low = f ? 12'(`SWR_TK_UP(`SWR_SHORT_OD_NS)) : 12'(`SWR_TK_UP(`SWR_SHORT_REG_NS));
        end else begin
          r.low = f ? 12'(`SWR_TK_UP(`SWR_W0_OD_NS)) : 12'(`SWR_TK_UP(`SWR_W0_REG_NS));
        end
        r.samp = r.low;
        r.total = f ? 12'(`SWR_TK_UP(`SWR_SLOT_OD_NS)) : 12'(`SWR_TK_UP(`SWR_SLOT_REG_NS));
      end
      default: begin
        r.low = f ? 12'(`SWR_TK_UP(`SWR_SHORT_OD_NS)) : 12'(`SWR_TK_UP(`SWR_SHORT_REG_NS));
        r.samp = f ? 12'(`SWR_TK_DN(`SWR_RD_OD_NS)) : 12'(`SWR_TK_DN(`SWR_RD_REG_NS));
        r.total = f ? 12'(`SWR_TK_UP(`SWR_SLOT_OD_NS)) : 12'(`SWR_TK_UP(`SWR_SLOT_REG_NS));
      end
    endcase
    return r;
  endfunction

  always_comb begin
    next_div = (div == 5'(`SWR_TICK_CYC - 1)) ? 5'h00 : 5'(div + 5'h01);
    next_t = t;
    next_busy = busy;
    next_done = 1'b0;
    next_smp = smp;
    next_oe_n = oe_n;
    next_kind = kind;
    next_tim = tim;
    next_fast_q = fast_q;
    if (!busy && i_start) begin
      // RULE_18: slot opens with our falling edge
      next_div = 5'h00;
      next_t = 12'h000;
      next_busy = 1'b1;
      next_oe_n = 1'b0;
      next_kind = i_kind;
      next_fast_q = i_fast;
      next_tim = slot_tim(i_kind, i_bit, i_fast);
    end else if (busy && div == 5'(`SWR_TICK_CYC - 1)) begin
      next_t = 12'(t + 12'h001);
      if (next_t == tim.low) begin
        next_oe_n = 1'b1;
      end
      // RULE_23: presence sampled inside its window
      if (next_t == tim.samp) begin
        next_smp = (kind == swr_pkg::SWR_K_RESET) ? ~i_dq : i_dq;
      end
      if (next_t == tim.total) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      div <= 5'h00;
      t <= 12'h000;
      busy <= 1'b0;
      done <= 1'b0;
      smp <= 1'b0;
      oe_n <= 1'b1;
      kind <= swr_pkg::SWR_K_RESET;
      tim <= '0;
      fast_q <= 1'b0;
    end else begin
      div <= next_div;
      t <= next_t;
      busy <= next_busy;
      done <= next_done;
      smp <= next_smp;
      oe_n <= next_oe_n;
      kind <= next_kind;
      tim <= next_tim;
      fast_q <= next_fast_q;
    end
  end

  // RULE_17: pull-down only, the line is never driven high
  assign o_dq = 1'b0;
  assign o_dq_oe_n = oe_n;
  assign o_done = done;
  assign o_bit = smp;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      low_cyc <= 17'h0_0000;
      slot_cyc <= 17'h0_0000;
    end else begin
      low_cyc <= oe_n ? 17'h0_0000 : 17'(low_cyc + 17'h0_0001);
      slot_cyc <= (!busy && i_start) ? 17'h0_0000 : 17'(slot_cyc + 17'h0_0001);
    end
  end

  property p_rst_reg_len;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    $rose(oe_n) && kind == swr_pkg::SWR_K_RESET && !fast_q |->
      low_cyc >= 17'(`SWR_CYC_UP(`SWR_RST_REG_MIN_NS)) && low_cyc <= 17'(`SWR_CYC_DN(`SWR_RST_REG_MAX_NS));
  endproperty
  a_rst_reg_len: assert property (p_rst_reg_len) else $error("regular reset length out of range"); // RULE_20
  property p_od_rst_len;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    $rose(oe_n) && kind == swr_pkg::SWR_K_RESET && fast_q |->
      low_cyc >= 17'(`SWR_CYC_UP(`SWR_RST_OD_MIN_NS)) && low_cyc <= 17'(`SWR_CYC_DN(`SWR_RST_OD_KEEP_NS));
  endproperty
  a_od_rst_len: assert property (p_od_rst_len) else $error("fast reset would drop fast speed"); // RULE_22
  property p_low_max;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    !oe_n && kind != swr_pkg::SWR_K_RESET |->
      low_cyc < (fast_q ? 17'(`SWR_CYC_DN(`SWR_IDLE_LOW_OD_NS)) : 17'(`SWR_CYC_DN(`SWR_IDLE_LOW_REG_NS)));
  endproperty
  a_low_max: assert property (p_low_max) else $error("slot held line low too long"); // RULE_16
  property p_slot_sync;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    $fell(oe_n) |-> $past(i_start) && busy ##1 busy;
  endproperty
  a_slot_sync: assert property (p_slot_sync) else $error("falling edge outside slot start"); // RULE_18
  property p_rate;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    done && kind != swr_pkg::SWR_K_RESET |->
      slot_cyc >= (fast_q ? 17'(`SWR_CYC_UP(`SWR_BIT_OD_MIN_NS)) : 17'(`SWR_CYC_UP(`SWR_BIT_REG_MIN_NS)));
  endproperty
  a_rate: assert property (p_rate) else $error("bit rate above limit"); // RULE_19
endmodule // swr_slot

// ---- verilog/swr_rom_master.sv ----
// How it works
// RULE_01: Reset pulse first, presence answers it
// RULE_02: Order: ROM command, memory command, data
// RULE_03: Six ROM commands, eight bits each
// RULE_04: 33h returns family, serial, check code
// RULE_05: Read identity only with one slave
// RULE_06: 55h plus 64 bits selects one slave
// RULE_07: CCh goes straight to memory command
// RULE_08: Multi-drop skip forbids read-type commands after
// RULE_09: Search: bit, complement, then master writes
// RULE_10: Search mismatch drops slave until reset
// RULE_11: 3Ch skips and sets fast speed
// RULE_12: Fast speed ends on 480us reset
// RULE_13: After multi-drop 3Ch, fast reset then select
// RULE_14: 69h match at fast speed enables fast
// RULE_15: Fast slaves stay fast, others regular
// RULE_16: Idle line high; limit low time
// RULE_17: Line driven only by open-drain pull-down
// RULE_18: Master falling edge starts every slot
// RULE_19: Rate at most 16.3k or 142k bit/s
// RULE_20: Regular reset low 480 to 960us
// RULE_21: Everything sent least significant bit first
// RULE_22: Reset up to 80us keeps fast speed
// RULE_23: Presence follows reset within fixed windows
`timescale 1ns/1ps
`include "swr_defines.svh"
module swr_rom_master (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_req_valid,
  input wire swr_pkg::swr_req_t i_req,
  input wire logic i_multi_drop,
  input wire logic i_dq,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output swr_pkg::swr_rsp_t o_rsp,
  output logic o_fast_speed_flag,
  output logic o_dq,
  output logic o_dq_oe_n
);
  swr_pkg::swr_state_t state, next_state;
  swr_pkg::swr_op_t op, next_op;
  swr_pkg::swr_phase_t phase, next_phase;
  swr_pkg::swr_kind_t kind, next_kind;
  swr_pkg::swr_rsp_t rsp, next_rsp;
  logic long_q, next_long, fast, next_fast, selpend, next_selpend, skipm, next_skipm;
  logic sa, next_sa, start, next_start, sbit, next_sbit, rsp_valid, next_rsp_valid;
  logic [63:0] sh, next_sh, res, next_res, ident, next_ident;
  logic [6:0] cnt, next_cnt;
  logic slot_done, slot_bit, slot_fast, srch_w;
  logic [7:0] cmd_code;

  function automatic logic [7:0] rom_code(input swr_pkg::swr_op_t o);
    case (o)
      swr_pkg::SWR_OP_READ_ID: return `SWR_CMD_READ_ID;
      swr_pkg::SWR_OP_MATCH: return `SWR_CMD_MATCH;
      swr_pkg::SWR_OP_SEARCH: return `SWR_CMD_SEARCH;
      swr_pkg::SWR_OP_OD_SKIP: return `SWR_CMD_OD_SKIP;
      swr_pkg::SWR_OP_OD_MATCH: return `SWR_CMD_OD_MATCH;
      default: return `SWR_CMD_SKIP;
    endcase
  endfunction

  function automatic logic legal(input swr_pkg::swr_op_t o, input swr_pkg::swr_phase_t ph, input logic multi,
                                 input logic sel, input logic skm);
    logic is_sel;
    is_sel = (o == swr_pkg::SWR_OP_MATCH) || (o == swr_pkg::SWR_OP_OD_MATCH) || (o == swr_pkg::SWR_OP_SEARCH);
    case (o)
      swr_pkg::SWR_OP_RESET: return 1'b1;
      // RULE_02: memory command and data only after a ROM command
      swr_pkg::SWR_OP_WRITE_BYTE: return ph == swr_pkg::SWR_PH_MEM || ph == swr_pkg::SWR_PH_DATA;
      // RULE_08: no reads after a multi-drop skip
      swr_pkg::SWR_OP_READ_BYTE: return ph == swr_pkg::SWR_PH_DATA && !skm;
      // RULE_05: identity read needs a single slave
      swr_pkg::SWR_OP_READ_ID: return ph == swr_pkg::SWR_PH_ROM && !multi && !sel;
      // RULE_13: select one slave after a multi-drop fast skip
      default: return ph == swr_pkg::SWR_PH_ROM && (is_sel || !sel);
    endcase
  endfunction

  assign cmd_code = rom_code(op);
  // RULE_09: write the bit both agree on, else the chosen branch
  assign srch_w = (sa != slot_bit) ? sa : sh[0];
  // RULE_12: a long reset always runs at regular timing
  assign slot_fast = fast && !(kind == swr_pkg::SWR_K_RESET && long_q);

  always_comb begin
    next_state = state;
    next_op = op;
    next_phase = phase;
    next_kind = kind;
    next_rsp = rsp;
    next_long = long_q;
    next_fast = fast;
    next_selpend = selpend;
    next_skipm = skipm;
    next_sa = sa;
    next_start = 1'b0;
    next_sbit = sbit;
    next_rsp_valid = 1'b0;
    next_sh = sh;
    next_res = res;
    next_ident = ident;
    next_cnt = cnt;
    if (state == swr_pkg::SWR_ST_IDLE) begin
      if (i_req_valid) begin
        next_op = i_req.op;
        next_long = i_req.long_rst;
        next_ident = i_req.id;
        next_cnt = 7'h00;
        next_res = 64'h0000_0000_0000_0000;
        next_rsp = '0;
        if (!legal(i_req.op, phase, i_multi_drop, selpend, skipm)) begin
          next_rsp.err = 1'b1;
          next_rsp_valid = 1'b1;
        end else begin
          next_start = 1'b1;
          next_kind = swr_pkg::SWR_K_WRITE;
          case (i_req.op)
            // RULE_01: transaction opens with a reset pulse
            swr_pkg::SWR_OP_RESET: begin
              next_state = swr_pkg::SWR_ST_RST;
              next_kind = swr_pkg::SWR_K_RESET;
            end
            swr_pkg::SWR_OP_WRITE_BYTE: begin
              next_sh = {56'h00_0000_0000_0000, i_req.data};
              next_sbit = i_req.data[0];
              next_state = swr_pkg::SWR_ST_BYTE_TX;
            end
            swr_pkg::SWR_OP_READ_BYTE: begin
              next_kind = swr_pkg::SWR_K_READ;
              next_state = swr_pkg::SWR_ST_BYTE_RX;
            end
            default: begin
              // RULE_03: eight-bit ROM command
              next_sh = {56'h00_0000_0000_0000, rom_code(i_req.op)};
              next_sbit = next_sh[0];
              next_state = swr_pkg::SWR_ST_CMD;
            end
          endcase
        end
      end
    end else if (slot_done) begin
      next_start = 1'b1;
      next_cnt = 7'(cnt + 7'h01);
      // RULE_21: shift out and in least significant bit first
      next_sh = sh >> 1;
      next_res = {slot_bit, res[63:1]};
      next_sbit = next_sh[0];
      case (state)
        swr_pkg::SWR_ST_RST: begin
          next_start = 1'b0;
          next_state = swr_pkg::SWR_ST_IDLE;
          next_rsp_valid = 1'b1;
          next_rsp.present = slot_bit;
          next_phase = slot_bit ? swr_pkg::SWR_PH_ROM : swr_pkg::SWR_PH_NONE;
          next_skipm = 1'b0;
          // RULE_12: long reset returns to regular speed
          if (long_q) begin
            next_fast = 1'b0;
            next_selpend = 1'b0;
          end
        end
        swr_pkg::SWR_ST_CMD: begin
          if (cnt == 7'(`SWR_BYTE_BITS - 1)) begin
            next_cnt = 7'h00;
            next_sh = ident;
            next_sbit = ident[0];
            case (op)
              // RULE_04: collect the 64-bit identity
              swr_pkg::SWR_OP_READ_ID: begin
                next_kind = swr_pkg::SWR_K_READ;
                next_state = swr_pkg::SWR_ST_ID_RX;
              end
              swr_pkg::SWR_OP_SEARCH: begin
                next_kind = swr_pkg::SWR_K_READ;
                next_state = swr_pkg::SWR_ST_SR_A;
              end
              // RULE_06: identity follows the match command
              swr_pkg::SWR_OP_MATCH: next_state = swr_pkg::SWR_ST_ID_TX;
              // RULE_14: fast-match identity goes at fast speed
              swr_pkg::SWR_OP_OD_MATCH: begin
                next_fast = 1'b1;
                next_state = swr_pkg::SWR_ST_ID_TX;
              end
              default: begin
                // RULE_07: skip goes straight to the memory command
                next_start = 1'b0;
                next_state = swr_pkg::SWR_ST_IDLE;
                next_rsp_valid = 1'b1;
                next_phase = swr_pkg::SWR_PH_MEM;
                next_skipm = i_multi_drop;
                // RULE_11: fast skip sets the speed flag
                if (op == swr_pkg::SWR_OP_OD_SKIP) begin
                  next_fast = 1'b1;
                  next_selpend = i_multi_drop;
                end
              end
            endcase
          end
        end
        swr_pkg::SWR_ST_SR_A: begin
          next_sa = slot_bit;
          next_sh = sh;
          next_res = res;
          next_cnt = cnt;
          next_state = swr_pkg::SWR_ST_SR_B;
        end
        swr_pkg::SWR_ST_SR_B: begin
          next_sh = sh;
          next_cnt = cnt;
          next_res = {srch_w, res[63:1]};
          next_sbit = srch_w;
          next_kind = swr_pkg::SWR_K_WRITE;
          next_state = swr_pkg::SWR_ST_SR_W;
          // RULE_10: both ones means no slave is left
          if (sa && slot_bit) begin
            next_start = 1'b0;
            next_state = swr_pkg::SWR_ST_IDLE;
            next_rsp_valid = 1'b1;
            next_rsp.err = 1'b1;
            next_phase = swr_pkg::SWR_PH_NONE;
          end
        end
        swr_pkg::SWR_ST_BYTE_TX, swr_pkg::SWR_ST_BYTE_RX: begin
          if (cnt == 7'(`SWR_BYTE_BITS - 1)) begin
            next_start = 1'b0;
            next_state = swr_pkg::SWR_ST_IDLE;
            next_rsp_valid = 1'b1;
            next_rsp.data = next_res[63:56];
            next_phase = swr_pkg::SWR_PH_DATA;
          end
        end
        default: begin
          if (state == swr_pkg::SWR_ST_SR_W) begin
            next_res = res;
            next_kind = swr_pkg::SWR_K_READ;
            next_state = swr_pkg::SWR_ST_SR_A;
          end
          if (cnt == 7'(`SWR_ID_BITS - 1)) begin
            // RULE_15: selection done, later slots keep current speed
            next_start = 1'b0;
            next_state = swr_pkg::SWR_ST_IDLE;
            next_rsp_valid = 1'b1;
            next_rsp.id = next_res;
            next_phase = swr_pkg::SWR_PH_MEM;
            next_selpend = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state <= swr_pkg::SWR_ST_IDLE;
      op <= swr_pkg::SWR_OP_RESET;
      phase <= swr_pkg::SWR_PH_NONE;
      kind <= swr_pkg::SWR_K_RESET;
      rsp <= '0;
      long_q <= 1'b0;
      fast <= 1'b0;
      selpend <= 1'b0;
      skipm <= 1'b0;
      sa <= 1'b0;
      start <= 1'b0;
      sbit <= 1'b0;
      rsp_valid <= 1'b0;
      sh <= 64'h0000_0000_0000_0000;
      res <= 64'h0000_0000_0000_0000;
      ident <= 64'h0000_0000_0000_0000;
      cnt <= 7'h00;
    end else begin
      state <= next_state;
      op <= next_op;
      phase <= next_phase;
      kind <= next_kind;
      rsp <= next_rsp;
      long_q <= next_long;
      fast <= next_fast;
      selpend <= next_selpend;
      skipm <= next_skipm;
      sa <= next_sa;
      start <= next_start;
      sbit <= next_sbit;
      rsp_valid <= next_rsp_valid;
      sh <= next_sh;
      res <= next_res;
      ident <= next_ident;
      cnt <= next_cnt;
    end
  end

  swr_slot u_slot (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(start),
    .i_kind(kind),
    .i_bit(sbit),
    .i_fast(slot_fast),
    .i_dq(i_dq),
    .o_done(slot_done),
    .o_bit(slot_bit),
    .o_dq(o_dq),
    .o_dq_oe_n(o_dq_oe_n)
  );

  assign o_req_ready = (state == swr_pkg::SWR_ST_IDLE);
  assign o_rsp_valid = rsp_valid;
  assign o_rsp = rsp;
  assign o_fast_speed_flag = fast;

  property p_idle_rel;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    state == swr_pkg::SWR_ST_IDLE && !start |-> o_dq_oe_n;
  endproperty
  a_idle_rel: assert property (p_idle_rel) else $error("line not released while idle"); // RULE_16
  property p_od_set;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    state == swr_pkg::SWR_ST_CMD && op == swr_pkg::SWR_OP_OD_SKIP && slot_done && cnt == 7'h07
      |=> fast && phase == swr_pkg::SWR_PH_MEM && o_rsp_valid;
  endproperty
  a_od_set: assert property (p_od_set) else $error("fast skip did not set speed flag"); // RULE_11
  property p_fast_clr;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    o_rsp_valid && op == swr_pkg::SWR_OP_RESET && long_q |-> !fast;
  endproperty
  a_fast_clr: assert property (p_fast_clr) else $error("long reset kept fast speed"); // RULE_12
  property p_order;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    i_req_valid && o_req_ready && i_req.op == swr_pkg::SWR_OP_READ_BYTE && phase != swr_pkg::SWR_PH_DATA
      |=> o_rsp_valid && o_rsp.err && state == swr_pkg::SWR_ST_IDLE;
  endproperty
  a_order: assert property (p_order) else $error("out of order request not refused"); // RULE_02
  property p_lsb;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    start && state == swr_pkg::SWR_ST_CMD |-> sbit == cmd_code[cnt[2:0]];
  endproperty
  a_lsb: assert property (p_lsb) else $error("command bit order wrong"); // RULE_21
  property p_pres;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    o_rsp_valid && op == swr_pkg::SWR_OP_RESET && !o_rsp.err
      |-> phase == (o_rsp.present ? swr_pkg::SWR_PH_ROM : swr_pkg::SWR_PH_NONE);
  endproperty
  a_pres: assert property (p_pres) else $error("phase not tied to presence"); // RULE_01
  c_presence: cover property (@(posedge i_core_clk) o_rsp_valid && o_rsp.present);
  c_search: cover property (@(posedge i_core_clk) o_rsp_valid && op == swr_pkg::SWR_OP_SEARCH && !o_rsp.err);
  c_od_match: cover property (@(posedge i_core_clk) state == swr_pkg::SWR_ST_ID_TX && fast && slot_done);
endmodule // swr_rom_master

// ---- sim/swr_slave_model.sv ----
`timescale 1ns/1ps
module swr_slave_model #(
  // Arbitrary identity value
  parameter logic [63:0] DEV_ID = 64'h1122_3344_5566_7788,
  parameter logic [7:0] MEM_DATA = 8'h3B
) (
  input wire logic i_dq,
  output logic o_pull
);
  localparam int IDLE = 0, CMD = 1, TX = 2, RX = 3, MEM = 4, SRCH = 5;
  int mode = IDLE, n = 0, k = 0;
  logic fast_speed_flag = 1'b0, od_prev = 1'b0, smp;
  logic [7:0] cmd, mem_cmd;
  logic [63:0] rx;
  realtime t0;
  initial o_pull = 1'b0;
  always @(negedge i_dq) begin
    t0 = $realtime;
    o_pull = (mode == TX || (mode == SRCH && k == 0)) ? !DEV_ID[n] : (mode == SRCH && k == 1) ? DEV_ID[n] :
      (mode == MEM && n > 7) ? !MEM_DATA[n % 8] : 1'b0;
    #(fast_speed_flag ? 3000 : 30000);
    smp = i_dq;
    o_pull = 1'b0;
    wait (i_dq === 1'b1);
    t0 = $realtime - t0;
    if (t0 >= 480000.0 || (fast_speed_flag && t0 >= 48000.0)) begin
      fast_speed_flag = fast_speed_flag && t0 < 480000.0;
      mode = CMD;
      n = 0;
      k = 0;
      #(fast_speed_flag ? 3000 : 30000);
      o_pull = 1'b1;
      #(fast_speed_flag ? 12000 : 100000);
      o_pull = 1'b0;
    end else if (mode == SRCH) begin
      // follow the written bit or drop out
      if (k == 2 && smp != DEV_ID[n]) mode = IDLE;
      if (k == 2) n = n + 1;
      k = (k + 1) % 3;
      if (mode == SRCH && n == 64) begin
        mode = MEM;
        n = 0;
      end
    end else begin
      cmd = {smp, cmd[7:1]};
      rx[n % 64] = smp;
      if (mode == MEM && n == 7) mem_cmd = cmd;
      n = n + 1;
      if (mode == CMD && n == 8) begin
        n = 0;
        od_prev = fast_speed_flag;
        mode = (cmd == 8'h33) ? TX : (cmd == 8'h55 || cmd == 8'h69) ? RX :
          (cmd == 8'hCC || cmd == 8'h3C) ? MEM : (cmd == 8'hF0) ? SRCH : IDLE;
        fast_speed_flag = fast_speed_flag || cmd == 8'h3C || cmd == 8'h69;
      end else if ((mode == TX || mode == RX) && n == 64) begin
        if (mode == RX && rx != DEV_ID) fast_speed_flag = od_prev;
        mode = (mode == TX || rx == DEV_ID) ? MEM : IDLE;
        n = 0;
      end
    end
  end
endmodule // swr_slave_model

// ---- sim/swr_rom_master_tb.sv ----
`timescale 1ns/1ps
module swr_rom_master_tb;
  localparam logic [63:0] DEV_ID = 64'h1122_3344_5566_7788;
  localparam logic [7:0] MEM_BYTE = 8'h3B;
  logic i_core_clk = 1'b0, i_sys_rst = 1'b1, i_req_valid = 1'b0, i_multi_drop = 1'b0;
  swr_pkg::swr_req_t i_req = '0;
  logic o_req_ready, o_rsp_valid, o_fast_speed_flag, o_dq, o_dq_oe_n, pull, line;
  swr_pkg::swr_rsp_t o_rsp, rsp;
  int failures = 0, total_checks = 0, cyc = 0, low_cnt = 0;
  // Wired line with pull-up
  assign line = !(o_dq_oe_n === 1'b0 || pull === 1'b1);
  always #5 i_core_clk = !i_core_clk;
  swr_rom_master i_swr_rom_master (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_req_valid(i_req_valid),
    .i_req(i_req), .i_multi_drop(i_multi_drop), .i_dq(line), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid),
    .o_rsp(o_rsp), .o_fast_speed_flag(o_fast_speed_flag), .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n));
  swr_slave_model #(.DEV_ID(DEV_ID), .MEM_DATA(MEM_BYTE)) i_swr_slave_model (.i_dq(line), .o_pull(pull));
  task automatic end_of_test();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    low_cnt <= (i_req_valid && o_req_ready) ? 0 : low_cnt + (o_dq_oe_n === 1'b0);
    if (cyc == 800000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_op(input swr_pkg::swr_op_t op, input logic lr, input logic [7:0] d, input logic md);
    @(posedge i_core_clk);
    i_req_valid <= 1'b1;
    i_req <= '{op: op, long_rst: lr, data: d, id: DEV_ID};
    i_multi_drop <= md;
    do @(negedge i_core_clk); while (o_req_ready !== 1'b1);
    @(posedge i_core_clk);
    i_req_valid <= 1'b0;
    do @(negedge i_core_clk); while (o_rsp_valid !== 1'b1);
    rsp = o_rsp;
  endtask
  task automatic t_refused();
    do_op(swr_pkg::SWR_OP_SKIP, 1'b0, 8'h00, 1'b0);
    chk(rsp.err, 1'b1);
    do_op(swr_pkg::SWR_OP_WRITE_BYTE, 1'b0, 8'h00, 1'b0);
    chk(rsp.err, 1'b1);
  endtask
  task automatic t_init();
    do_op(swr_pkg::SWR_OP_RESET, 1'b1, 8'h00, 1'b0);
    chk(rsp.present, 1'b1);
    chk(low_cnt >= 48000 && low_cnt <= 96000, 1'b1);
    do_op(swr_pkg::SWR_OP_READ_ID, 1'b0, 8'h00, 1'b1);
    chk(rsp.err, 1'b1);
  endtask
  task automatic t_fast_skip();
    do_op(swr_pkg::SWR_OP_OD_SKIP, 1'b0, 8'h00, 1'b1);
    chk(rsp.err, 1'b0);
    chk(o_fast_speed_flag, 1'b1);
    chk(i_swr_slave_model.fast_speed_flag, 1'b1);
    do_op(swr_pkg::SWR_OP_WRITE_BYTE, 1'b0, 8'h0F, 1'b1);
    chk(rsp.err, 1'b0);
    do_op(swr_pkg::SWR_OP_READ_BYTE, 1'b0, 8'h00, 1'b1);
    chk(rsp.err, 1'b1);
  endtask
  task automatic t_select();
    do_op(swr_pkg::SWR_OP_RESET, 1'b0, 8'h00, 1'b1);
    chk(rsp.present, 1'b1);
    chk(low_cnt <= 8000, 1'b1);
    chk(o_fast_speed_flag, 1'b1);
    do_op(swr_pkg::SWR_OP_SKIP, 1'b0, 8'h00, 1'b1);
    chk(rsp.err, 1'b1);
    do_op(swr_pkg::SWR_OP_OD_MATCH, 1'b0, 8'h00, 1'b1);
    chk(rsp.err, 1'b0);
    chk(i_swr_slave_model.mode, 4);
  endtask
  task automatic t_mem();
    do_op(swr_pkg::SWR_OP_WRITE_BYTE, 1'b0, 8'hC4, 1'b0);
    chk(i_swr_slave_model.mem_cmd, 8'hC4);
    do_op(swr_pkg::SWR_OP_READ_BYTE, 1'b0, 8'h00, 1'b0);
    chk(rsp.data, MEM_BYTE);
  endtask
  task automatic t_read_id();
    do_op(swr_pkg::SWR_OP_RESET, 1'b0, 8'h00, 1'b0);
    chk(rsp.present, 1'b1);
    do_op(swr_pkg::SWR_OP_READ_ID, 1'b0, 8'h00, 1'b0);
    chk(rsp.id, DEV_ID);
  endtask
  task automatic t_search();
    do_op(swr_pkg::SWR_OP_RESET, 1'b0, 8'h00, 1'b0);
    do_op(swr_pkg::SWR_OP_SKIP, 1'b0, 8'h00, 1'b0);
    chk(rsp.err, 1'b0);
    chk(i_swr_slave_model.mode, 4);
    do_op(swr_pkg::SWR_OP_RESET, 1'b0, 8'h00, 1'b0);
    chk(rsp.present, 1'b1);
    do_op(swr_pkg::SWR_OP_SEARCH, 1'b0, 8'h00, 1'b0);
    chk(rsp.err, 1'b0);
    chk(rsp.id, DEV_ID);
    chk(i_swr_slave_model.mode, 4);
  endtask
  task automatic t_slow_reset();
    do_op(swr_pkg::SWR_OP_RESET, 1'b1, 8'h00, 1'b0);
    chk(o_fast_speed_flag, 1'b0);
    chk(i_swr_slave_model.fast_speed_flag, 1'b0);
    chk(rsp.present, 1'b1);
  endtask
  initial begin
    repeat (5) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    t_refused();
    t_init();
    t_fast_skip();
    t_select();
    t_mem();
    t_read_id();
    t_search();
    t_slow_reset();
    end_of_test();
  end
endmodule // swr_rom_master_tb
